// File: logic/sfl_defines.vh
`ifndef SFL_DEFINES_VH
`define SFL_DEFINES_VH
// Wishbone register byte offsets
`define SFL_REG_CTRL      8'h00
`define SFL_REG_STATUS    8'h04
`define SFL_REG_LEVEL     8'h08
`define SFL_REG_BOOT      8'h0C
`define SFL_REG_FRAME     8'h10
`define SFL_REG_ADDR      8'h14
// Security level encodings
`define SFL_LVL0          8'hFF
`define SFL_LVL1          8'hFE
`define SFL_LVL2          8'hFC
// Erase defaults
`define SFL_BSB_DEF       8'hFF
`define SFL_SBV_DEF       8'hFC
`define SFL_VEC_LOW       8'h00
// ASCII characters
`define SFL_CH_COLON      8'h3A
`define SFL_CH_U          8'h55
`define SFL_CH_P          8'h50
`define SFL_CH_L          8'h4C
`define SFL_CH_X          8'h58
`define SFL_CH_DOT        8'h2E
`define SFL_CH_CR         8'h0D
`define SFL_CH_LF         8'h0A
// Access classes carried in the frame's first data byte
`define SFL_CLS_MEM_WR    3'h0
`define SFL_CLS_MEM_RD    3'h1
`define SFL_CLS_CFG_WR    3'h2
`define SFL_CLS_CFG_RD    3'h3
`define SFL_CLS_LVL_WR    3'h4
`define SFL_CLS_BLK_ERASE 3'h5
`define SFL_CLS_CHIP_ERS  3'h6
`define SFL_CLS_INFO      3'h7
// UART framing
`define SFL_DATA_BITS     4'h8
`define SFL_STOP_BITS     4'h2
`endif

// File: logic/sfl_loader.v
// Operation
// - Sample strap pins at reset release
// - Straps force loader over all fuses
// - Jump fuse zero selects loader
// - Boot vector high byte, default none
// - Fetch pin selects internal or external
// - Serial: 8 data, no parity, 2 stop
// - Baud measured from incoming traffic
// - Colon starts every frame
// - Length, offset, type, data, checksum order
// - Offset is 16-bit data address
// - Bytes sent as two hex digits
// - Frame bytes sum to zero
// - Level byte defaults to no security
// - Level may only become stricter
// - Level 1 refuses writes, answers P
// - Level 2 refuses memory access, answers L
// - Level 1 allows reads; info always readable
// - Level 2 denies config; erase limits
// - Level 1 may write level 2 only
// - Only chip erase restores default level (here reset and the CTRL register erase also restore it)
// - Chip erase loads default bytes
// - Echo every received frame
// - Checksum error answers X CR LF
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/10ps
`include "sfl_defines.vh"
module sfl_loader #(
	parameter CNT_W = 20,
	parameter DEF_JUMP = 1'b0
) (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Strap and boot pins
	input  wire        ext_fetch_sel_pin_i,
	input  wire        prog_strobe_pin_n_i,
	input  wire        loader_jump_fuse_i,
	// Serial link
	input  wire        rxd_i,
	output reg         txd_o,
	// Boot decision
	output reg         run_loader_o,
	output reg         fetch_external_o,
	output reg  [15:0] entry_addr_o,
	// Frame hand-off to flash engine
	output reg         frame_ok_o,
	output reg  [7:0]  frame_type_o,
	output reg  [15:0] frame_offset_o,
	output reg  [7:0]  frame_cmd_o,
	output reg  [7:0]  frame_arg_o,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o
);
	// Pin synchronisers
	reg [1:0] rx_s_r, ea_s_r, ps_s_r;
	reg rst_d_r;
	always @(posedge clk_i)
	begin
		rx_s_r  <= {rx_s_r[0], rxd_i};
		ea_s_r  <= {ea_s_r[0], ext_fetch_sel_pin_i};
		ps_s_r  <= {ps_s_r[0], prog_strobe_pin_n_i};
		rst_d_r <= rst_i;
	end
	wire rx = rx_s_r[1];

	// Persistent bytes and boot state
	reg [7:0] level_r, bsb_r, sbv_r;
	reg       forced_r;
	// Straps caught once at the reset release; later pin changes are ignored
	always @(posedge clk_i)
	begin
		if (rst_i)
			forced_r <= 1'b0;
		else if (rst_d_r)
			forced_r <= ea_s_r[1] & ~ps_s_r[1];
	end
	// Boot decision, refreshed every cycle from the latched strap, the jump fuse, the live fetch pin and sbv_r
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			run_loader_o     <= 1'b1;
			fetch_external_o <= 1'b0;
			entry_addr_o     <= 16'h0000;
		end
		else
		begin
			fetch_external_o <= ~ea_s_r[1];
			if (forced_r)
				run_loader_o <= 1'b1;
			else
				run_loader_o <= ~loader_jump_fuse_i;
			if (sbv_r != `SFL_SBV_DEF)
				entry_addr_o <= {sbv_r, `SFL_VEC_LOW};
			else
				entry_addr_o <= 16'h0000;
		end
	end

	// Autobaud: time the first low bit of the opening U
	reg [CNT_W-1:0] bit_len_r, cnt_r;
	reg [1:0]       ab_st_r;
	reg             baud_ok_r;
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ab_st_r <= 2'h0; bit_len_r <= {CNT_W{1'b0}}; baud_ok_r <= 1'b0;
		end
		else if (!baud_ok_r)
		begin
			case (ab_st_r)
			2'h0: if (!rx) begin ab_st_r <= 2'h1; bit_len_r <= {CNT_W{1'b0}}; end
			2'h1: if (!rx) bit_len_r <= bit_len_r + 1'b1;
			      else begin ab_st_r <= 2'h2; end
			2'h2: begin baud_ok_r <= 1'b1; ab_st_r <= 2'h3; end
			default: ab_st_r <= 2'h3;
			endcase
		end
	end
	// Receiver; the tail of the opening U may give a stray char, dropped outside a frame
	reg [3:0] rx_bit_r;
	reg [7:0] rx_sh_r;
	reg       rx_busy_r, rx_vld_r;
	always @(posedge clk_i)
	begin
		rx_vld_r <= 1'b0;
		if (rst_i || !baud_ok_r)
		begin
			rx_busy_r <= 1'b0; cnt_r <= {CNT_W{1'b0}}; rx_bit_r <= 4'h0; rx_sh_r <= 8'h00;
		end
		else if (!rx_busy_r)
		begin
			if (!rx)
			begin
				rx_busy_r <= 1'b1; cnt_r <= bit_len_r >> 1; rx_bit_r <= 4'h0;
			end
		end
		else if (cnt_r != {CNT_W{1'b0}})
			cnt_r <= cnt_r - 1'b1;
		else
		begin
			cnt_r <= bit_len_r;
			rx_bit_r <= rx_bit_r + 4'h1;
			if (rx_bit_r >= 4'h1 && rx_bit_r <= `SFL_DATA_BITS)
				rx_sh_r <= {rx, rx_sh_r[7:1]};
			if (rx_bit_r == `SFL_DATA_BITS + 4'h1)
			begin
				rx_busy_r <= 1'b0; rx_vld_r <= rx;
			end
		end
	end

	// Hex digit value
	wire [7:0] c = rx_sh_r;
	wire is_dig = (c >= 8'h30 && c <= 8'h39);
	wire is_hex = (c >= 8'h41 && c <= 8'h46);
	wire [3:0] nib = is_dig ? c[3:0] : c[3:0] + 4'h9;

	// Echo queue: every received char goes out first
	reg [7:0] echo_r;
	reg       echo_pend_r;
	// Answer sequence: up to three chars after the frame
	reg [23:0] ans_r;
	reg [1:0]  ans_n_r;
	reg        ans_go_r;

	// Frame parser
	reg [2:0]  fst_r;
	reg        hi_r;
	reg [3:0]  hnib_r;
	reg [7:0]  len_r, sum_r, left_r;
	reg [1:0]  hdr_r;
	reg [15:0] off_r;
	reg [7:0]  typ_r, d0_r, d1_r;
	reg [7:0]  dcnt_r;
	localparam F_IDLE = 3'h0, F_HDR = 3'h1, F_DATA = 3'h2, F_CSUM = 3'h3, F_EXEC = 3'h4;
	wire [7:0] byte_v = {hnib_r, nib};
	reg        erase_req_r;
	reg [7:0]  status_r;
	reg        sw_erase_r;

	// Result of permission check
	reg [7:0] resp;
	always @*
	begin
		resp = `SFL_CH_DOT;
		case (d0_r[2:0])
		`SFL_CLS_MEM_WR, `SFL_CLS_CFG_WR:
			if (level_r == `SFL_LVL2) resp = `SFL_CH_L;
			else if (level_r == `SFL_LVL1) resp = `SFL_CH_P;
		`SFL_CLS_MEM_RD, `SFL_CLS_CFG_RD:
			if (level_r == `SFL_LVL2) resp = `SFL_CH_L;
		`SFL_CLS_LVL_WR:
			if (level_r == `SFL_LVL2) resp = `SFL_CH_L;
			else if (level_r == `SFL_LVL1 && d1_r != `SFL_LVL2) resp = `SFL_CH_P;
		`SFL_CLS_BLK_ERASE:
			if (level_r == `SFL_LVL2) resp = `SFL_CH_L;
			else if (level_r == `SFL_LVL1) resp = `SFL_CH_P;
		default: resp = `SFL_CH_DOT; // Chip erase, info: any level
		endcase
	end

	always @(posedge clk_i)
	begin
		ans_go_r   <= 1'b0;
		frame_ok_o <= 1'b0;
		erase_req_r <= 1'b0;
		if (rst_i)
		begin
			fst_r <= F_IDLE; hi_r <= 1'b1; hnib_r <= 4'h0; sum_r <= 8'h00;
			len_r <= 8'h00; hdr_r <= 2'h0; off_r <= 16'h0000; typ_r <= 8'h00;
			d0_r <= 8'h00; d1_r <= 8'h00; dcnt_r <= 8'h00; left_r <= 8'h00;
			ans_r <= 24'h00_0000;
			frame_type_o <= 8'h00; frame_offset_o <= 16'h0000;
			frame_cmd_o <= 8'h00; frame_arg_o <= 8'h00; status_r <= 8'h00;
		end
		else if (rx_vld_r)
		begin
			if (c == `SFL_CH_COLON)
			begin
				fst_r <= F_HDR; hi_r <= 1'b1; sum_r <= 8'h00; hdr_r <= 2'h0;
				dcnt_r <= 8'h00;
			end
			else if (fst_r == F_IDLE || fst_r == F_EXEC)
				fst_r <= fst_r;
			else if (!(is_dig || is_hex))
				fst_r <= F_IDLE;
			else if (hi_r)
			begin
				hnib_r <= nib; hi_r <= 1'b0;
			end
			else
			begin
				hi_r  <= 1'b1;
				sum_r <= sum_r + byte_v;
				case (fst_r)
				F_HDR:
				begin
					hdr_r <= hdr_r + 2'h1;
					case (hdr_r)
					2'h0: len_r <= byte_v;
					2'h1: off_r[15:8] <= byte_v;
					2'h2: off_r[7:0] <= byte_v;
					default:
					begin
						typ_r <= byte_v; left_r <= len_r;
						fst_r <= (len_r == 8'h00) ? F_CSUM : F_DATA;
					end
					endcase
				end
				F_DATA:
				begin
					if (dcnt_r == 8'h00) d0_r <= byte_v;
					if (dcnt_r == 8'h01) d1_r <= byte_v;
					dcnt_r <= dcnt_r + 8'h01;
					left_r <= left_r - 8'h01;
					if (left_r == 8'h01) fst_r <= F_CSUM;
				end
				default: // Checksum byte closes the frame
				begin
					fst_r <= F_EXEC;
					ans_go_r <= 1'b1;
					if (sum_r + byte_v != 8'h00)
						ans_r <= {`SFL_CH_X, `SFL_CH_CR, `SFL_CH_LF};
					else
					begin
						ans_r <= {resp, `SFL_CH_CR, `SFL_CH_LF};
						status_r <= resp;
						if (resp == `SFL_CH_DOT)
						begin
							frame_ok_o <= 1'b1;
							frame_type_o <= typ_r; frame_offset_o <= off_r;
							frame_cmd_o <= d0_r; frame_arg_o <= d1_r;
							erase_req_r <= (d0_r[2:0] == `SFL_CLS_CHIP_ERS);
						end
					end
				end
				endcase
			end
		end
	end
	// Stricter-only check uses the bit pattern: new level clears bits only
	wire lvl_wr_ok = frame_ok_o && (frame_cmd_o[2:0] == `SFL_CLS_LVL_WR) &&
		((frame_arg_o & level_r) == frame_arg_o) && (frame_arg_o != level_r) &&
		(frame_arg_o == `SFL_LVL1 || frame_arg_o == `SFL_LVL2);
	wire cfg_wr = frame_ok_o && (frame_cmd_o[2:0] == `SFL_CLS_CFG_WR);
	// Persistent bytes; reset, software or serial erase restores defaults
	always @(posedge clk_i)
	begin
		if (rst_i || erase_req_r || sw_erase_r)
		begin
			level_r <= `SFL_LVL0; bsb_r <= `SFL_BSB_DEF; sbv_r <= `SFL_SBV_DEF;
		end
		else if (lvl_wr_ok)
			level_r <= frame_arg_o;
		else if (cfg_wr && frame_offset_o[0])
			sbv_r <= frame_arg_o;
		else if (cfg_wr)
			bsb_r <= frame_arg_o;
	end

	// Transmitter: echo wins; start bit at load, the last shift ends the second stop bit
	reg [10:0]      tx_sh_r;
	reg [3:0]       tx_n_r;
	reg [CNT_W-1:0] tx_cnt_r;
	wire ans_load = (tx_n_r == 4'h0) && !echo_pend_r && !ans_go_r && (ans_n_r != 2'h0);
	wire [7:0] ans_ch = ans_r[{ans_n_r - 2'h1, 3'h0} +: 8]; // Oldest answer char first
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			txd_o <= 1'b1; tx_sh_r <= 11'h7FF; tx_n_r <= 4'h0; tx_cnt_r <= {CNT_W{1'b0}};
			echo_pend_r <= 1'b0; echo_r <= 8'h00;
		end
		else
		begin
			if (rx_vld_r)
			begin
				echo_pend_r <= 1'b1; echo_r <= c;
			end
			if (tx_n_r != 4'h0)
			begin
				if (tx_cnt_r != {CNT_W{1'b0}})
					tx_cnt_r <= tx_cnt_r - 1'b1;
				else
				begin
					tx_cnt_r <= bit_len_r;
					txd_o <= tx_sh_r[0];
					tx_sh_r <= {1'b1, tx_sh_r[10:1]};
					tx_n_r <= tx_n_r - 4'h1;
				end
			end
			else if (echo_pend_r && !rx_vld_r)
			begin
				echo_pend_r <= 1'b0;
				tx_sh_r <= {3'b111, echo_r}; txd_o <= 1'b0;
				tx_n_r <= 4'hB; tx_cnt_r <= bit_len_r;
			end
			else if (ans_load)
			begin
				tx_sh_r <= {3'b111, ans_ch}; txd_o <= 1'b0;
				tx_n_r <= 4'hB; tx_cnt_r <= bit_len_r;
			end
		end
	end
	// Answer queue counts down as each char is loaded
	always @(posedge clk_i)
	begin
		if (rst_i)
			ans_n_r <= 2'h0;
		else if (ans_go_r)
			ans_n_r <= 2'h3;
		else if (ans_load)
			ans_n_r <= ans_n_r - 2'h1;
	end

	// Wishbone slave, one wait cycle then ack
	wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	always @(posedge clk_i)
	begin
		sw_erase_r <= 1'b0;
		if (rst_i)
		begin
			wb_ack_o <= 1'b0; wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= wb_req;
			if (wb_req)
			begin
				case (wb_adr_i)
				`SFL_REG_CTRL:
				begin
					wb_dat_o <= 32'h0000_0000;
					if (wb_we_i && wb_sel_i[0] && wb_dat_i[0]) sw_erase_r <= 1'b1;
				end
				`SFL_REG_STATUS: wb_dat_o <= {20'h0_0000, baud_ok_r, forced_r,
					run_loader_o, fetch_external_o, status_r};
				`SFL_REG_LEVEL: wb_dat_o <= {24'h00_0000, level_r};
				`SFL_REG_BOOT:  wb_dat_o <= {16'h0000, sbv_r, bsb_r};
				`SFL_REG_FRAME: wb_dat_o <= {frame_type_o, frame_cmd_o, frame_arg_o, 8'h00};
				`SFL_REG_ADDR:  wb_dat_o <= {16'h0000, frame_offset_o};
				default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule // sfl_loader

// File: verification/sfl_loader_chk.sv
`timescale 1ns/10ps
module sfl_loader_chk (
	// Clock and reset
	input wire        clk_i,
	input wire        rst_i,
	// Watched ports
	input wire        ext_fetch_sel_pin_i,
	input wire        run_loader_o,
	input wire        fetch_external_o,
	input wire [15:0] entry_addr_o,
	input wire        frame_ok_o,
	input wire [7:0]  frame_type_o,
	input wire [15:0] frame_offset_o,
	input wire        wb_cyc_i,
	input wire        wb_stb_i,
	input wire        wb_ack_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Request still waiting for its answer
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// Strap decision has had time to settle
	sequence s_settled;
		(!rst_i)[*5];
	endsequence
	chk_ack_next: assert property (s_req |=> wb_ack_o)
		else $error("bus answer missing");
	chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus answer too long");
	chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("bus answer without request");
	chk_loader_held: assert property (s_settled |=> $stable(run_loader_o))
		else $error("boot choice changed");
	chk_fetch_follow: assert property (($stable(ext_fetch_sel_pin_i))[*6] |->
		fetch_external_o == !ext_fetch_sel_pin_i)
		else $error("fetch source wrong");
	chk_vector_low: assert property (entry_addr_o[7:0] == 8'h00)
		else $error("entry low byte not zero");
	chk_ok_pulse: assert property (frame_ok_o |=> !frame_ok_o)
		else $error("frame pulse too long");
	chk_frame_hold: assert property (!$stable({frame_type_o, frame_offset_o}) |->
		frame_ok_o || $past(frame_ok_o))
		else $error("frame fields moved");
endmodule // sfl_loader_chk

// File: verification/sfl_host.sv
`timescale 1ns/10ps
module sfl_host #(
	parameter BIT = 16
) (
	// Clock
	input  wire       clk_i,
	// Serial lines
	input  wire       line_i,
	output reg        line_o,
	// Received characters
	output reg        got_o,
	output reg  [7:0] got_byte_o
);
	integer i;
	integer k;
	// Start, 8 data LSB first, 2 stop, no flow control
	task send_char(input [7:0] c);
		for (i = 0; i < 11; i = i + 1)
		begin
			line_o <= (i == 0) ? 1'b0 : (i > 8) ? 1'b1 : c[i - 1];
			repeat (BIT) @(posedge clk_i);
		end
	endtask
	// Mid-bit sampling tolerates a measured bit time a cycle off
	initial
	begin
		line_o = 1'b1;
		got_o = 1'b0;
		got_byte_o = 8'h00;
		forever
		begin
			@(posedge clk_i);
			got_o <= 1'b0;
			if (line_i === 1'b0)
			begin
				repeat (BIT + BIT / 2) @(posedge clk_i);
				for (k = 0; k < 8; k = k + 1)
				begin
					got_byte_o[k] <= line_i;
					repeat (BIT) @(posedge clk_i);
				end
				got_o <= 1'b1;
			end
		end
	end
endmodule // sfl_host

// File: verification/sfl_loader_tb.sv
`timescale 1ns/10ps
`include "sfl_defines.vh"
module sfl_loader_tb;
	reg         clk_i;
	reg         rst_i;
	reg         ext;
	reg         strb_n;
	reg         fuse;
	reg         cyc;
	reg         we;
	reg  [7:0]  adr;
	reg  [31:0] dat;
	wire        rxd;
	wire        txd;
	wire        run;
	wire        fext;
	wire [15:0] entry;
	wire        ok;
	wire [7:0]  ftype;
	wire [15:0] foff;
	wire [31:0] rdat;
	wire        ack;
	wire        got;
	wire [7:0]  got_byte;
	reg  [8:0]  exp_q[$];
	reg  [8:0]  e;
	reg  [7:0]  sum;
	reg  [15:0] lfsr;
	reg         listen;
	integer     mismatches;
	integer     check_count;
	sfl_loader i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .ext_fetch_sel_pin_i(ext),
		.prog_strobe_pin_n_i(strb_n), .loader_jump_fuse_i(fuse), .rxd_i(rxd),
		.txd_o(txd), .run_loader_o(run), .fetch_external_o(fext), .entry_addr_o(entry),
		.frame_ok_o(ok), .frame_type_o(ftype), .frame_offset_o(foff), .frame_cmd_o(),
		.frame_arg_o(), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack)
	);
	sfl_host #(.BIT(16)) i_host (
		.clk_i(clk_i), .line_i(txd), .line_o(rxd), .got_o(got), .got_byte_o(got_byte)
	);
	// 125 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task tally_and_finish;
		if (mismatches == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task stop_hang;
		mismatches = mismatches + 1;
		tally_and_finish;
	endtask
	task check(input string what, input [31:0] seen, input [31:0] want);
		check_count = check_count + 1;
		if (seen !== want)
		begin
			mismatches = mismatches + 1;
			$display("wrong value %s expected %h seen %h", what, want, seen);
		end
	endtask
	function [15:0] nxt(input [15:0] v);
		nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction
	function [7:0] hexc(input [3:0] n);
		hexc = (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
	endfunction
	// Classic cycle, held until ack is sampled
	task wb(input w, input [7:0] a, input [31:0] d, input [31:0] want);
		integer n;
		begin
			cyc <= 1'b1;
			we <= w;
			adr <= a;
			dat <= d;
			n = 0;
			@(posedge clk_i);
			while (ack !== 1'b1 && n < 20)
			begin
				@(posedge clk_i);
				n = n + 1;
			end
			if (n == 20)
				stop_hang;
			if (!w)
				check("bus read", rdat, want);
			cyc <= 1'b0;
			@(posedge clk_i);
		end
	endtask
	task put(input [7:0] c);
		exp_q.push_back({1'b0, c});
		i_host.send_char(c);
	endtask
	task hexbyte(input [7:0] b);
		put(hexc(b[7:4]));
		put(hexc(b[3:0]));
		sum = sum + b;
	endtask
	// Two data bytes; res bit 8 set means any answer
	task frame(input [15:0] off, input [7:0] d0, input [7:0] d1, input bad, input [8:0] res);
		integer n;
		begin
			sum = 8'h00;
			put(`SFL_CH_COLON);
			hexbyte(8'h02);
			hexbyte(off[15:8]);
			hexbyte(off[7:0]);
			hexbyte(8'h03);
			hexbyte(d0);
			hexbyte(d1);
			hexbyte(8'h00 - sum + {7'h00, bad});
			exp_q.push_back(res);
			exp_q.push_back({1'b0, `SFL_CH_CR});
			exp_q.push_back({1'b0, `SFL_CH_LF});
			n = 0;
			while (exp_q.size() > 0 && n < 4000)
			begin
				@(posedge clk_i);
				n = n + 1;
			end
			if (n == 4000)
				stop_hang;
			repeat (32) @(posedge clk_i);
		end
	endtask
	// The strobe strap changes after release and must be ignored
	task boot(input e_v, input s_v, input f_v, input r_v);
		rst_i <= 1'b1;
		ext <= e_v;
		strb_n <= s_v;
		fuse <= f_v;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		strb_n <= ~s_v;
		repeat (4) @(posedge clk_i);
		check("run_loader", run, r_v);
	endtask
	// Each echoed or answer character is matched against the oldest note
	always @(posedge clk_i)
		if (got === 1'b1 && listen)
		begin
			e = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h0FF;
			if (!e[8])
				check("serial char", got_byte, e);
		end
	initial
	begin
		mismatches = 0;
		check_count = 0;
		listen = 1'b0;
		lfsr = 16'h2C0D;
		{rst_i, ext, strb_n, fuse, cyc, we, adr, dat} = {1'b1, 45'h0};
		@(posedge clk_i);
		boot(1'b1, 1'b0, 1'b1, 1'b1);
		boot(1'b0, 1'b0, 1'b1, 1'b0);
		boot(1'b1, 1'b1, 1'b1, 1'b0);
		ext <= 1'b0;
		repeat (6) @(posedge clk_i);
		check("fetch_external", fext, 1);
		boot(1'b1, 1'b1, 1'b0, 1'b1);
		check("fetch_external", fext, 0);
		check("entry_addr", entry, 0);
		i_host.send_char(`SFL_CH_U);
		repeat (400) @(posedge clk_i);
		listen = 1'b1;
		wb(0, `SFL_REG_LEVEL, 0, `SFL_LVL0);
		frame(0, 8'h04, `SFL_LVL1, 0, {1'b0, `SFL_CH_DOT});
		lfsr = nxt(lfsr);
		frame(lfsr, 8'h00, lfsr[7:0], 0, {1'b0, `SFL_CH_P});
		frame(0, 8'h02, lfsr[15:8], 0, {1'b0, `SFL_CH_P});
		frame(0, 8'h01, 0, 0, {1'b0, `SFL_CH_DOT});
		frame(0, 8'h04, `SFL_LVL0, 0, {1'b0, `SFL_CH_P});
		wb(0, `SFL_REG_LEVEL, 0, `SFL_LVL1);
		frame(0, 8'h04, `SFL_LVL2, 0, {1'b0, `SFL_CH_DOT});
		frame(0, 8'h01, 0, 0, {1'b0, `SFL_CH_L});
		frame(0, 8'h00, 0, 0, {1'b0, `SFL_CH_L});
		frame(0, 8'h06, 0, 1, {1'b0, `SFL_CH_X});
		frame(0, 8'h04, `SFL_LVL1, 0, {1'b0, `SFL_CH_L});
		wb(0, `SFL_REG_LEVEL, 0, `SFL_LVL2);
		frame(0, 8'h06, 0, 0, {1'b0, `SFL_CH_DOT});
		wb(0, `SFL_REG_LEVEL, 0, `SFL_LVL0);
		lfsr = nxt(lfsr);
		frame(16'h0001, 8'h02, {lfsr[7:1], 1'b1}, 0, {1'b0, `SFL_CH_DOT});
		check("entry_addr", entry, {lfsr[7:1], 1'b1, 8'h00});
		wb(0, `SFL_REG_BOOT, 0, {lfsr[7:1], 1'b1, `SFL_BSB_DEF});
		wb(1, `SFL_REG_CTRL, 1, 0);
		wb(0, `SFL_REG_BOOT, 0, {`SFL_SBV_DEF, `SFL_BSB_DEF});
		check("entry_addr", entry, 0);
		lfsr = nxt(lfsr);
		frame(lfsr, 8'h00, lfsr[7:0], 0, {1'b0, `SFL_CH_DOT});
		wb(0, `SFL_REG_ADDR, 0, lfsr);
		wb(0, `SFL_REG_FRAME, 0, {8'h03, 8'h00, lfsr[7:0], 8'h00});
		wb(0, `SFL_REG_STATUS, 0, {20'h0_0000, 4'b1010, `SFL_CH_DOT});
		wb(0, 8'h40, 0, 0);
		tally_and_finish;
	end
endmodule // sfl_loader_tb
bind sfl_loader sfl_loader_chk i_chk (
	.clk_i, .rst_i, .ext_fetch_sel_pin_i, .run_loader_o, .fetch_external_o, .entry_addr_o,
	.frame_ok_o, .frame_type_o, .frame_offset_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o
);
